// *** design/dcec_pkg.sv ***
// package: register map, fields and reset values for the channel event control block
//
// Behaviour
// - abort select field bits 23:16; selected irq aborts transfer and sets abort flag
// - start select field bits 15:8; selected irq 0..255 starts a transfer
// - writing one to bit 7 forces a transfer start; bit reads zero
// - writing one to bit 6 aborts current transfer; bit reads zero
// - bit 5 set: pattern match while the channel is enabled aborts and clears channel enable
// - bit 4 set: start irq starts a cell transfer, else ignored
// - bit 3 set: abort irq aborts transfer, else ignored
// - bits 31:24 and 2:0 are unimplemented and read zero
package dcec_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] DCEC_ECON_OFS = 8'h00;
    localparam logic [7:0] DCEC_STAT_OFS = 8'h04;
    localparam logic [7:0] DCEC_MASK_OFS = 8'h08;
    localparam logic [7:0] DCEC_CTRL_OFS = 8'h0c;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int DCEC_ABSEL_LSB = 16;
    localparam int DCEC_STSEL_LSB = 8;
    localparam int DCEC_FORCE_BIT = 7;
    localparam int DCEC_ABORT_BIT = 6;
    localparam int DCEC_PATTERN_ABORT_ENABLE_BIT = 5;
    localparam int DCEC_STEN_BIT = 4;
    localparam int DCEC_ABEN_BIT = 3;
    localparam logic [7:0] DCEC_SEL_RST = 8'hff;
    localparam logic [31:0] DCEC_ECON_RST = 32'h00ffff00;
    localparam logic [31:0] DCEC_ECON_WMASK = 32'h00ffff38;
    // status bits: 0 start event, 1 abort event, 2 pattern abort
    localparam int DCEC_NEV = 3;
    localparam logic [1:0] DCEC_RESP_OK = 2'b00;
    localparam logic [1:0] DCEC_RESP_DEC = 2'b11;

    // event configuration carried to the trigger logic
    typedef struct packed {
        logic [7:0] abortSel;
        logic [7:0] startSel;
        logic pattern_abort_enable;
        logic startEn;
        logic abortEn;
    } dcec_cfg_t;
endpackage

// *** design/dcec_top.sv ***
// module: channel event control with an axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module dcec_top
    import dcec_pkg::*;
#(
    parameter int NIRQ = 256
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NIRQ-1:0] irqLines,
    input wire logic patternMatch,
    output logic startXfer,
    output logic abortXfer,
    output logic channelEnable,
    output logic irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] econ_ff;
    logic channel_enable_ff;
    logic [DCEC_NEV-1:0] stat_ff, mask_ff;
    logic [NIRQ-1:0] irqS1_ff, irqS2_ff, irqS3_ff;
    logic awHeld_ff, wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bValid_ff, rValid_ff, awRdy_ff, wRdy_ff, arRdy_ff;
    logic [31:0] rData_ff;
    logic [1:0] bResp_ff, rResp_ff;
    logic start_ff, abort_ff, irq_ff, patS1_ff, patS2_ff;
    dcec_cfg_t cfg;

    // ----------------------------------------
    // write channel capture
    // ----------------------------------------
    // address and data are taken independently, in either order
    wire awFire = s_axi_awvalid && awRdy_ff;
    wire wFire = s_axi_wvalid && wRdy_ff;
    wire wrDo = awHeld_ff && wHeld_ff && !bValid_ff;
    wire arFire = s_axi_arvalid && arRdy_ff;
    wire [31:0] strbMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
                            {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
    wire wEcon = wrDo && awAddr_ff == DCEC_ECON_OFS;
    wire wStat = wrDo && awAddr_ff == DCEC_STAT_OFS;
    wire wMask = wrDo && awAddr_ff == DCEC_MASK_OFS;
    wire wCtrl = wrDo && awAddr_ff == DCEC_CTRL_OFS;
    wire wOk = wEcon || wStat || wMask || wCtrl;
    wire [31:0] wEff = wData_ff & strbMask;

    assign cfg.abortSel = econ_ff[DCEC_ABSEL_LSB +: 8];
    assign cfg.startSel = econ_ff[DCEC_STSEL_LSB +: 8];
    assign cfg.pattern_abort_enable = econ_ff[DCEC_PATTERN_ABORT_ENABLE_BIT];
    assign cfg.startEn = econ_ff[DCEC_STEN_BIT];
    assign cfg.abortEn = econ_ff[DCEC_ABEN_BIT];

    // ----------------------------------------
    // event detection
    // ----------------------------------------
    // rising edge on the synchronised line: one event per pulse
    // single event per pulse
    wire [NIRQ-1:0] irqRise = irqS2_ff & ~irqS3_ff;
    wire startIrq = cfg.startEn && irqRise[cfg.startSel];
    wire abortIrq = cfg.abortEn && irqRise[cfg.abortSel];
    wire forceCmd = wEcon && wStrb_ff[0] && wData_ff[DCEC_FORCE_BIT];
    wire abortCmd = wEcon && wStrb_ff[0] && wData_ff[DCEC_ABORT_BIT];
    wire patAbort = cfg.pattern_abort_enable && patS2_ff && channel_enable_ff;
    wire nxt_start = startIrq || forceCmd;
    wire nxt_abort = abortIrq || abortCmd || patAbort;
    wire [DCEC_NEV-1:0] evSet = {patAbort, abortIrq, nxt_start};
    // set wins over a write-one clear
    wire [DCEC_NEV-1:0] nxt_stat = (stat_ff & ~(wStat ? wEff[DCEC_NEV-1:0] : '0)) | evSet;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // command bits never stored, read zero
    // unimplemented bits read zero
    // low address bits ignored, same as on the write side
    wire [7:0] arAlign = {s_axi_araddr[7:2], 2'b00};
    wire rdEcon = arAlign == DCEC_ECON_OFS;
    wire rdStat = arAlign == DCEC_STAT_OFS;
    wire rdMask = arAlign == DCEC_MASK_OFS;
    wire rdCtrl = arAlign == DCEC_CTRL_OFS;
    wire rdOk = rdEcon || rdStat || rdMask || rdCtrl;
    wire [31:0] rdVal = rdEcon ? (econ_ff & DCEC_ECON_WMASK) :
                        rdStat ? {29'h0, stat_ff} :
                        rdMask ? {29'h0, mask_ff} :
                        rdCtrl ? {31'h0, channel_enable_ff} : 32'h0;

    // ----------------------------------------
    // synchronisers for irq lines and pattern match
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irqS1_ff <= '0;
            irqS2_ff <= '0;
            irqS3_ff <= '0;
            patS1_ff <= 1'b0;
            patS2_ff <= 1'b0;
        end else begin
            irqS1_ff <= irqLines;
            irqS2_ff <= irqS1_ff;
            irqS3_ff <= irqS2_ff;
            patS1_ff <= patternMatch;
            patS2_ff <= patS1_ff;
        end
    end

    // ----------------------------------------
    // registers and event outputs
    // ----------------------------------------
    // selects all ones, enables zero
    always_ff @(posedge clk) begin
        if (rst) begin
            econ_ff <= DCEC_ECON_RST;
            channel_enable_ff <= 1'b0;
            stat_ff <= '0;
            mask_ff <= '0;
            start_ff <= 1'b0;
            abort_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            if (wEcon) begin
                econ_ff <= (econ_ff & ~(DCEC_ECON_WMASK & strbMask))
                         | (wData_ff & DCEC_ECON_WMASK & strbMask);
            end
            if (wMask) begin
                mask_ff <= wEff[DCEC_NEV-1:0];
            end
            if (patAbort) begin
                channel_enable_ff <= 1'b0;
            end else if (wCtrl && wStrb_ff[0]) begin
                channel_enable_ff <= wData_ff[0];
            end
            stat_ff <= nxt_stat;
            start_ff <= nxt_start;
            abort_ff <= nxt_abort;
            irq_ff <= |(nxt_stat & mask_ff);
        end
    end

    // ----------------------------------------
    // axi4-lite handshakes
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= '0;
            wData_ff <= '0;
            wStrb_ff <= '0;
            awRdy_ff <= 1'b1;
            wRdy_ff <= 1'b1;
            bValid_ff <= 1'b0;
            bResp_ff <= DCEC_RESP_OK;
            arRdy_ff <= 1'b1;
            rValid_ff <= 1'b0;
            rData_ff <= '0;
            rResp_ff <= DCEC_RESP_OK;
        end else begin
            if (awFire) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= {s_axi_awaddr[7:2], 2'b00};
                awRdy_ff <= 1'b0;
            end
            if (wFire) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                wRdy_ff <= 1'b0;
            end
            if (wrDo) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bValid_ff <= 1'b1;
                bResp_ff <= wOk ? DCEC_RESP_OK : DCEC_RESP_DEC;
            end else if (bValid_ff && s_axi_bready) begin
                bValid_ff <= 1'b0;
                awRdy_ff <= 1'b1;
                wRdy_ff <= 1'b1;
            end
            if (arFire) begin
                arRdy_ff <= 1'b0;
                rValid_ff <= 1'b1;
                rData_ff <= rdVal;
                rResp_ff <= rdOk ? DCEC_RESP_OK : DCEC_RESP_DEC;
            end else if (rValid_ff && s_axi_rready) begin
                rValid_ff <= 1'b0;
                arRdy_ff <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awRdy_ff;
    assign s_axi_wready = wRdy_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;
    assign s_axi_arready = arRdy_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;
    assign startXfer = start_ff;
    assign abortXfer = abort_ff;
    assign channelEnable = channel_enable_ff;
    assign irq = irq_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // edge of the selected start line, seen after the synchronisers
    sequence sStartPulse;
        cfg.startEn && irqS2_ff[cfg.startSel] && !irqS3_ff[cfg.startSel];
    endsequence
    // edge of the selected abort line, seen after the synchronisers
    sequence sAbortPulse;
        cfg.abortEn && irqS2_ff[cfg.abortSel] && !irqS3_ff[cfg.abortSel];
    endsequence
    // pattern seen while the channel is still enabled
    sequence sPatHit;
        cfg.pattern_abort_enable && patS2_ff && channel_enable_ff;
    endsequence
    // both write channels held and no answer pending yet
    sequence sWrReady;
        awHeld_ff && wHeld_ff && !bValid_ff;
    endsequence

    // event triggers
    a_start_on_irq: assert property (sStartPulse |=> startXfer)
        else $error("selected start irq did not start transfer");
    a_abort_on_irq: assert property (sAbortPulse |=> abortXfer && stat_ff[1])
        else $error("selected abort irq did not abort and flag");
    a_force_start: assert property (forceCmd |=> startXfer)
        else $error("force command did not start transfer");
    a_abort_cmd: assert property (abortCmd |=> abortXfer)
        else $error("abort command did not abort");
    a_pattern_abort: assert property (sPatHit |=> abortXfer && !channel_enable_ff)
        else $error("pattern match did not abort and disable");
    a_start_gated: assert property (!cfg.startEn && !forceCmd |=> !startXfer)
        else $error("start seen with start irq disabled");
    a_abort_gated: assert property (!cfg.abortEn && !abortCmd && !patAbort |=>
        !abortXfer)
        else $error("abort seen with abort irq disabled");
    // a line held high must not restart the channel every cycle
    a_single_event: assert property (startXfer && !$past(forceCmd) |=>
        !startXfer || $past(forceCmd))
        else $error("one irq pulse gave two start events");

    // register read back and reset state
    a_reserved_zero: assert property (rValid_ff && $past(arFire) && $past(rdEcon) |->
        rData_ff[31:24] == 8'h00 && rData_ff[7:6] == 2'b00 && rData_ff[2:0] == 3'b000)
        else $error("reserved or command bits read nonzero");
    a_reset_values: assert property ($fell(rst) |-> cfg.abortSel == DCEC_SEL_RST
        && cfg.startSel == DCEC_SEL_RST && !cfg.pattern_abort_enable && !cfg.startEn && !cfg.abortEn
        && !channel_enable_ff && stat_ff == '0 && !irq)
        else $error("bad reset value of event control");

    // status, interrupt and enable
    a_status_sticky: assert property (!wStat |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
        else $error("status bit dropped without a clear");
    a_irq_level: assert property (irq == |(stat_ff & $past(mask_ff)))
        else $error("interrupt output does not follow masked status");
    a_enable_write: assert property (wCtrl && wStrb_ff[0] && !patAbort |=>
        channel_enable_ff == $past(wData_ff[0]))
        else $error("channel enable write not taken");

    // bus handshakes
    a_write_answer: assert property (sWrReady |=>
        s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not retired");
    a_read_answer: assert property (arFire |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data missing");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read data not retired");
endmodule
`default_nettype wire

// *** tb/dcec_src_model.sv ***
// partner model: interrupt request sources and the transfer engine pattern flag
`timescale 1ns/10ps
`default_nettype none
module dcec_src_model (
    input wire logic clk,
    input wire logic fireReq,
    input wire logic [7:0] fireNum,
    input wire logic patReq,
    output logic [255:0] irqLines,
    output logic patternMatch
);
    logic [2:0] holdCnt;
    initial begin
        irqLines = 256'h0;
        patternMatch = 1'b0;
        holdCnt = 3'h0;
    end
    // ----------------------------------------
    // request source
    // ----------------------------------------
    // a line is held a few cycles, then dropped so it may fire again
    always @(posedge clk) begin
        patternMatch <= patReq;
        if (fireReq) begin
            irqLines[fireNum] <= 1'b1;
            holdCnt <= 3'h4;
        end else if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
        end else begin
            irqLines <= 256'h0; // released lines go low, not left floating
        end
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// testbench: register bus, event triggers, pattern abort and interrupt of the block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    import dcec_pkg::*;
    logic clk = 1'b0, rst = 1'b1, awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
    logic awR, wR, bV, arR, rV, startXfer, abortXfer, channelEnable, irq, patternMatch;
    logic [7:0] awA = 8'h0, arA = 8'h0, fireNum = 8'h0;
    logic [31:0] wD = 32'h0, rD, rdData;
    logic [1:0] bResp, rResp, resp;
    logic [255:0] irqLines;
    logic fireReq = 1'b0, patReq = 1'b0;
    logic [3:0] wS = 4'hf;
    int errCount = 0, totalChecks = 0, startCnt = 0, abortCnt = 0;
    always #2.5 clk = ~clk;
    // pulse counters: deltas show exactly one event per request
    always @(posedge clk) begin
        if (startXfer === 1'b1) startCnt++;
        if (abortXfer === 1'b1) abortCnt++;
    end
    dcec_src_model src_u (.clk(clk), .fireReq(fireReq), .fireNum(fireNum), .patReq(patReq),
        .irqLines(irqLines), .patternMatch(patternMatch));
    dcec_top #(.NIRQ(256)) dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS),
        .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
        .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
        .irqLines(irqLines), .patternMatch(patternMatch), .startXfer(startXfer),
        .abortXfer(abortXfer), .channelEnable(channelEnable), .irq(irq));
    // ----------------------------------------
    // bus master tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // each channel released at its own handshake edge; a bound cuts a hang short
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awA <= a; wD <= d; awV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (awR) awV <= 1'b0;
            if (wR) wV <= 1'b0;
            if (bV) break;
        end
        bR <= 1'b0;
        resp = bResp;
        if (n == 200) begin errCount++; tally_and_finish(); end
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        arA <= a; arV <= 1'b1; rR <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (arR) arV <= 1'b0;
            if (rV) break;
        end
        rR <= 1'b0;
        rdData = rD;
        resp = rResp;
        if (n == 200) begin errCount++; tally_and_finish(); end
    endtask
    // one request (irq line or pattern flag), then count the pulses it caused
    task automatic ev(input logic pat, input logic [7:0] n, input int es, input int ea);
        int s0, a0;
        s0 = startCnt;
        a0 = abortCnt;
        @(posedge clk);
        if (pat) patReq <= 1'b1;
        else fireReq <= 1'b1;
        fireNum <= n;
        @(posedge clk);
        fireReq <= 1'b0;
        repeat (12) @(posedge clk);
        patReq <= 1'b0;
        `CHK("start pulses", es, startCnt - s0)
        `CHK("abort pulses", ea, abortCnt - a0)
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_fields;
        rd(DCEC_ECON_OFS); `CHK("econ reset", DCEC_ECON_RST, rdData)
        rd(8'h10); `CHK("unmapped resp", DCEC_RESP_DEC, resp)
        `CHK("unmapped data", 32'h0, rdData)
        wr(8'h10, 32'hffffffff); `CHK("unmapped wr resp", DCEC_RESP_DEC, resp)
        wr(DCEC_ECON_OFS, 32'hffffffff); `CHK("econ wr resp", DCEC_RESP_OK, resp)
        repeat (4) @(posedge clk);
        `CHK("forced starts", 1, startCnt)
        `CHK("cmd aborts", 1, abortCnt)
        rd(DCEC_ECON_OFS); `CHK("econ ones", DCEC_ECON_WMASK, rdData)
        // lane 1 only: command bits in lane 0 must not act
        wS <= 4'h2;
        wr(DCEC_ECON_OFS + 8'h01, 32'hffffaaff);
        wS <= 4'hf;
        repeat (4) @(posedge clk);
        `CHK("masked force", 1, startCnt)
        rd(DCEC_ECON_OFS + 8'h02); `CHK("econ lane", 32'h00ffaa38, rdData)
        $display("test fields done");
    endtask
    task automatic t_irq;
        wr(DCEC_ECON_OFS, 32'h00090538);
        ev(1'b0, 8'h05, 1, 0);
        ev(1'b0, 8'h09, 0, 1);
        ev(1'b0, 8'h07, 0, 0);
        rd(DCEC_STAT_OFS); `CHK("status flags", 32'h3, rdData)
        wr(DCEC_ECON_OFS, 32'h00090500);
        ev(1'b0, 8'h05, 0, 0);
        ev(1'b0, 8'h09, 0, 0);
        wr(DCEC_ECON_OFS, 32'h00ff0010);
        ev(1'b0, 8'h00, 1, 0);
        $display("test irq done");
    endtask
    task automatic t_pattern;
        wr(DCEC_CTRL_OFS, 32'h1);
        ev(1'b1, 8'h00, 0, 0);
        `CHK("enable kept", 1'b1, channelEnable)
        wr(DCEC_ECON_OFS, 32'h00ffff20);
        ev(1'b1, 8'h00, 0, 1);
        `CHK("enable cleared", 1'b0, channelEnable)
        $display("test pattern done");
    endtask
    task automatic t_intr;
        `CHK("irq masked", 1'b0, irq)
        wr(DCEC_MASK_OFS, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        wr(DCEC_STAT_OFS, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        rd(DCEC_STAT_OFS); `CHK("status left", 32'h5, rdData)
        $display("test intr done");
    endtask
    // mid-run reset after configuring: enable, irq, event control and status must return to their reset values
    task automatic t_reset;
        wr(DCEC_MASK_OFS, 32'h4);
        wr(DCEC_CTRL_OFS, 32'h1);
        wr(DCEC_ECON_OFS, 32'h00123418);
        `CHK("irq before reset", 1'b1, irq)
        `CHK("enable before reset", 1'b1, channelEnable)
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        `CHK("enable reset", 1'b0, channelEnable)
        `CHK("irq reset", 1'b0, irq)
        rd(DCEC_ECON_OFS); `CHK("econ after reset", DCEC_ECON_RST, rdData)
        rd(DCEC_STAT_OFS); `CHK("status after reset", 32'h0, rdData)
        $display("test reset done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_fields();
        t_irq();
        t_pattern();
        t_intr();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
